/* sccr_pkg.sv */
// Constants and types shared by the switch configuration capability register slice.
package sccr_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_MSI_UPPER = 8'h54;
  localparam logic [7:0] OFF_MSI_DATA = 8'h58;
  localparam logic [7:0] OFF_PD_CTRL = 8'h5C;
  localparam logic [7:0] OFF_PD_WINDOW = 8'h60;
  localparam logic [7:0] OFF_VENDOR_HDR = 8'h64;
  localparam logic [7:0] OFF_TEST0 = 8'h68;
  localparam logic [7:0] OFF_TEST1 = 8'h6C;
  localparam logic [7:0] OFF_TIMER_OVR = 8'h70;

  // ---------------------------------------------------------------
  // Constant register contents and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PD_CAP_ID = 8'h03;
  localparam logic [7:0] PD_NEXT_PTR = 8'h64;
  localparam logic [7:0] VENDOR_CAP_ID = 8'h09;
  localparam logic [7:0] VENDOR_NEXT_PTR = 8'hB0;
  localparam logic [15:0] VENDOR_LENGTH = 16'h0034;
  localparam logic [31:0] TEST0_RESET = 32'h04001060;
  localparam logic [31:0] TEST1_RESET = 32'h04000800;
  localparam logic [31:0] MSI_UPPER_RESET = 32'h00000000;
  localparam logic [15:0] MSI_DATA_RESET = 16'h0000;
  localparam logic [31:0] PD_WINDOW_RESET = 32'h00000000;
  localparam logic [5:0] PD_ADDR_RESET = 6'h00;
  localparam logic PD_OP_RESET = 1'b0;
  localparam logic [11:0] REPLAY_RESET = 12'h000;
  localparam logic [13:0] ACK_RESET = 14'h0000;
  localparam logic VGA_DECODE_ON = 1'b1;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PD_ADDR_LSB = 18;
  localparam int PD_OP_BIT = 31;
  localparam int REPLAY_LSB = 0;
  localparam int REPLAY_EN_BIT = 12;
  localparam int PM_DIS_BIT = 13;
  localparam int MSI_DIS_BIT = 14;
  localparam int ACK_LSB = 16;
  localparam int ACK_EN_BIT = 30;
  localparam int VGA_BIT = 31;

  // ---------------------------------------------------------------
  // Product data handshake states
  // ---------------------------------------------------------------
  typedef enum logic
  {
    SCCR_IDLE = 1'b0,
    SCCR_BUSY = 1'b1
  } sccr_pd_state_e;

endpackage : sccr_pkg

/* sccr_regs.sv */
// Configuration capability register slice with the product data EEPROM handshake.

// Behaviour
// - Downstream: 32-bit RW upper message address at 54h, reset zero.
// - Downstream: 16-bit RW message data in 15:0, upper bits reserved.
// - Upstream: product data header reads id 03h and next pointer 64h.
// - Six-bit RW table dword address in bits 23:18, reset zero.
// - Writing 0 to bit 31 starts a read; bit rises when done.
// - Writing 1 to bit 31 starts a write; bit falls when done.
// - Data word returns the last value read from the table; resets zero.
// - Data word written supplies the value stored into the table.
// - Vendor header reads id 09h and next pointer B0h.
// - Vendor header bits 31:16 read the length 0034h.
// - Two RW test words reset to 0400_1060h and 0400_0800h.
// - 12-bit RW user replay timeout in bits 11:0, reset zero.
// - Bit 12 set makes the replay timer use the user value.
// - 14-bit RW user acknowledge latency in bits 29:16, reset zero.
// - Bit 30 set makes the latency timer use the user value.
// - Timer fields and disable bits 13, 14 may be loaded by autoload.
// - Bit 31 of the latency word reads 1, VGA decode enabled.
// - The 64-bit message address capability is in effect downstream only; upstream, 54h reads zero.
module sccr_regs #(
  parameter bit UPSTREAM = 1'b1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic ld_wr,
  input wire logic [31:0] ld_data,
  output logic ee_req,
  output logic ee_write,
  output logic [5:0] ee_addr,
  output logic [31:0] ee_wdata,
  input wire logic ee_done,
  input wire logic [31:0] ee_rdata,
  input wire logic [11:0] builtin_replay,
  input wire logic [13:0] builtin_ack,
  output logic [11:0] replay_limit,
  output logic [13:0] ack_limit,
  output logic pm_cap_disable,
  output logic msi_cap_disable,
  output logic [31:0] msi_upper_addr,
  output logic [15:0] msi_data,
  output logic [31:0] test_word0,
  output logic [31:0] test_word1
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [31:0] upper_reg, upper_next;
  logic [15:0] mdata_reg, mdata_next;
  logic [5:0] pd_addr_reg, pd_addr_next;
  logic pd_op_reg, pd_op_next;
  logic [31:0] pd_data_reg, pd_data_next;
  sccr_pkg::sccr_pd_state_e state_reg, state_next;
  logic [31:0] test0_reg, test0_next;
  logic [31:0] test1_reg, test1_next;
  logic [11:0] replay_reg, replay_next;
  logic replay_en_reg, replay_en_next;
  logic [13:0] ack_reg, ack_next;
  logic ack_en_reg, ack_en_next;
  logic pm_dis_reg, pm_dis_next;
  logic msi_dis_reg, msi_dis_next;
  logic [11:0] replay_lim_reg, replay_lim_next;
  logic [13:0] ack_lim_reg, ack_lim_next;
  logic ack_out_reg, ack_out_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] wmask;
  logic wr;
  logic [31:0] timer_word;
  logic [31:0] mdata_merge, timer_merge;

  function automatic logic [31:0] sccr_be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : sccr_be_mask

  function automatic logic [31:0] sccr_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [31:0] m);
    return (old & ~m) | (nw & m);
  endfunction : sccr_merge

  assign wmask = sccr_be_mask(cfg_be);
  assign wr = cfg_req && cfg_wr;
  // Read-only bits 13 and 14 change only through the load port.
  assign timer_word = {sccr_pkg::VGA_DECODE_ON, ack_en_reg, ack_reg, 1'b0, msi_dis_reg,
                       pm_dis_reg, replay_en_reg, replay_reg};
  assign mdata_merge = sccr_merge({16'h0000, mdata_reg}, cfg_wdata, wmask);
  assign timer_merge = sccr_merge(timer_word, cfg_wdata, wmask);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    upper_next = upper_reg;
    mdata_next = mdata_reg;
    pd_addr_next = pd_addr_reg;
    pd_op_next = pd_op_reg;
    pd_data_next = pd_data_reg;
    state_next = state_reg;
    test0_next = test0_reg;
    test1_next = test1_reg;
    replay_next = replay_reg;
    replay_en_next = replay_en_reg;
    ack_next = ack_reg;
    ack_en_next = ack_en_reg;
    pm_dis_next = pm_dis_reg;
    msi_dis_next = msi_dis_reg;
    if (wr && !UPSTREAM && cfg_addr == sccr_pkg::OFF_MSI_UPPER)
    begin
      upper_next = sccr_merge(upper_reg, cfg_wdata, wmask);
    end
    if (wr && !UPSTREAM && cfg_addr == sccr_pkg::OFF_MSI_DATA)
    begin
      mdata_next = mdata_merge[15:0];
    end
    unique case (state_reg)
      sccr_pkg::SCCR_IDLE:
      begin
        // A new command is taken only while no EEPROM cycle is running.
        if (wr && UPSTREAM && cfg_addr == sccr_pkg::OFF_PD_CTRL)
        begin
          if (cfg_be[2])
          begin
            pd_addr_next = cfg_wdata[sccr_pkg::PD_ADDR_LSB +: 6];
          end
          if (cfg_be[3])
          begin
            pd_op_next = cfg_wdata[sccr_pkg::PD_OP_BIT];
            state_next = sccr_pkg::SCCR_BUSY;
          end
        end
        if (wr && UPSTREAM && cfg_addr == sccr_pkg::OFF_PD_WINDOW)
        begin
          pd_data_next = sccr_merge(pd_data_reg, cfg_wdata, wmask);
        end
      end
      sccr_pkg::SCCR_BUSY:
      begin
        if (ee_done)
        begin
          state_next = sccr_pkg::SCCR_IDLE;
          pd_op_next = !pd_op_reg;
          if (!pd_op_reg)
          begin
            pd_data_next = ee_rdata;
          end
        end
      end
    endcase
    if (wr && cfg_addr == sccr_pkg::OFF_TEST0)
    begin
      test0_next = sccr_merge(test0_reg, cfg_wdata, wmask);
    end
    if (wr && cfg_addr == sccr_pkg::OFF_TEST1)
    begin
      test1_next = sccr_merge(test1_reg, cfg_wdata, wmask);
    end
    if (ld_wr)
    begin
      replay_next = ld_data[sccr_pkg::REPLAY_LSB +: 12];
      replay_en_next = ld_data[sccr_pkg::REPLAY_EN_BIT];
      pm_dis_next = ld_data[sccr_pkg::PM_DIS_BIT];
      msi_dis_next = ld_data[sccr_pkg::MSI_DIS_BIT];
      ack_next = ld_data[sccr_pkg::ACK_LSB +: 14];
      ack_en_next = ld_data[sccr_pkg::ACK_EN_BIT];
    end
    else if (wr && cfg_addr == sccr_pkg::OFF_TIMER_OVR)
    begin
      replay_next = timer_merge[sccr_pkg::REPLAY_LSB +: 12];
      replay_en_next = cfg_be[1] ? cfg_wdata[sccr_pkg::REPLAY_EN_BIT] : replay_en_reg;
      ack_next = timer_merge[sccr_pkg::ACK_LSB +: 14];
      ack_en_next = cfg_be[3] ? cfg_wdata[sccr_pkg::ACK_EN_BIT] : ack_en_reg;
    end
    replay_lim_next = replay_en_reg ? replay_reg : builtin_replay;
    ack_lim_next = ack_en_reg ? ack_reg : builtin_ack;
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb
  begin
    ack_out_next = cfg_req;
    rdata_next = 32'h00000000;
    if (cfg_req && !cfg_wr)
    begin
      unique case (cfg_addr)
        sccr_pkg::OFF_MSI_UPPER: rdata_next = UPSTREAM ? 32'h00000000 : upper_reg;
        sccr_pkg::OFF_MSI_DATA: rdata_next = UPSTREAM ? 32'h00000000 : {16'h0000, mdata_reg};
        sccr_pkg::OFF_PD_CTRL:
        begin
          if (UPSTREAM)
          begin
            rdata_next = {pd_op_reg, 7'h00, pd_addr_reg, 2'h0, sccr_pkg::PD_NEXT_PTR,
                          sccr_pkg::PD_CAP_ID};
          end
        end
        sccr_pkg::OFF_PD_WINDOW: rdata_next = UPSTREAM ? pd_data_reg : 32'h00000000;
        sccr_pkg::OFF_VENDOR_HDR:
        begin
          rdata_next = {sccr_pkg::VENDOR_LENGTH, sccr_pkg::VENDOR_NEXT_PTR,
                        sccr_pkg::VENDOR_CAP_ID};
        end
        sccr_pkg::OFF_TEST0: rdata_next = test0_reg;
        sccr_pkg::OFF_TEST1: rdata_next = test1_reg;
        sccr_pkg::OFF_TIMER_OVR: rdata_next = timer_word;
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      upper_reg <= sccr_pkg::MSI_UPPER_RESET;
      mdata_reg <= sccr_pkg::MSI_DATA_RESET;
      pd_addr_reg <= sccr_pkg::PD_ADDR_RESET;
      pd_op_reg <= sccr_pkg::PD_OP_RESET;
      pd_data_reg <= sccr_pkg::PD_WINDOW_RESET;
      state_reg <= sccr_pkg::SCCR_IDLE;
      test0_reg <= sccr_pkg::TEST0_RESET;
      test1_reg <= sccr_pkg::TEST1_RESET;
      replay_reg <= sccr_pkg::REPLAY_RESET;
      replay_en_reg <= 1'b0;
      ack_reg <= sccr_pkg::ACK_RESET;
      ack_en_reg <= 1'b0;
      pm_dis_reg <= 1'b0;
      msi_dis_reg <= 1'b0;
      replay_lim_reg <= 12'h000;
      ack_lim_reg <= 14'h0000;
      ack_out_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else if (ce)
    begin
      upper_reg <= upper_next;
      mdata_reg <= mdata_next;
      pd_addr_reg <= pd_addr_next;
      pd_op_reg <= pd_op_next;
      pd_data_reg <= pd_data_next;
      state_reg <= state_next;
      test0_reg <= test0_next;
      test1_reg <= test1_next;
      replay_reg <= replay_next;
      replay_en_reg <= replay_en_next;
      ack_reg <= ack_next;
      ack_en_reg <= ack_en_next;
      pm_dis_reg <= pm_dis_next;
      msi_dis_reg <= msi_dis_next;
      replay_lim_reg <= replay_lim_next;
      ack_lim_reg <= ack_lim_next;
      ack_out_reg <= ack_out_next;
      rdata_reg <= rdata_next;
    end
  end

  assign cfg_ack = ack_out_reg;
  assign cfg_rdata = rdata_reg;
  assign ee_req = (state_reg == sccr_pkg::SCCR_BUSY);
  assign ee_write = pd_op_reg;
  assign ee_addr = pd_addr_reg;
  assign ee_wdata = pd_data_reg;
  assign replay_limit = replay_lim_reg;
  assign ack_limit = ack_lim_reg;
  assign pm_cap_disable = pm_dis_reg;
  assign msi_cap_disable = msi_dis_reg;
  assign msi_upper_addr = upper_reg;
  assign msi_data = mdata_reg;
  assign test_word0 = test0_reg;
  assign test_word1 = test1_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_upper_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    ce && wr && !UPSTREAM && cfg_addr == sccr_pkg::OFF_MSI_UPPER && cfg_be == 4'hF
    |=> msi_upper_addr == $past(cfg_wdata))
    else $error("Upper message address not written.");

  a_msi_rsvd_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    ce && cfg_req && !cfg_wr && cfg_addr == sccr_pkg::OFF_MSI_DATA
    |=> cfg_rdata[31:16] == 16'h0000)
    else $error("Message data reserved bits not zero.");

  a_pd_header: assert property (@(posedge core_clk) disable iff (!arst_n)
    ce && UPSTREAM && cfg_req && !cfg_wr && cfg_addr == sccr_pkg::OFF_PD_CTRL
    |=> cfg_rdata[15:0] == 16'h6403 && cfg_ack)
    else $error("Product data header wrong.");

  a_pd_start: assert property (@(posedge core_clk) disable iff (!arst_n)
    ce && UPSTREAM && !ee_req && wr && cfg_addr == sccr_pkg::OFF_PD_CTRL && cfg_be[3:2] == 2'h3
    |=> ee_req && ee_addr == $past(cfg_wdata[23:18]) && ee_write == $past(cfg_wdata[31]))
    else $error("Product data cycle not started.");

  a_read_done: assert property (@(posedge core_clk) disable iff (!arst_n)
    ce && ee_req && ee_done && !ee_write
    |=> !ee_req && pd_op_reg && pd_data_reg == $past(ee_rdata))
    else $error("Read completion not flagged.");

  a_write_done: assert property (@(posedge core_clk) disable iff (!arst_n)
    ce && ee_req && ee_done && ee_write |=> !ee_req && !pd_op_reg && ee_wdata == $past(ee_wdata))
    else $error("Write completion not flagged.");

  a_flag_held: assert property (@(posedge core_clk) disable iff (!arst_n)
    ee_req && !ee_done |=> ee_req && $stable(pd_op_reg))
    else $error("Operation bit moved during a cycle.");

  a_vendor_hdr: assert property (@(posedge core_clk) disable iff (!arst_n)
    ce && cfg_req && !cfg_wr && cfg_addr == sccr_pkg::OFF_VENDOR_HDR |=> cfg_rdata == 32'h0034B009)
    else $error("Vendor header wrong.");

  a_replay_select: assert property (@(posedge core_clk) disable iff (!arst_n)
    ce && replay_en_reg |=> replay_limit == $past(replay_reg))
    else $error("Replay limit ignores user value.");

  a_vga_bit: assert property (@(posedge core_clk) disable iff (!arst_n)
    ce && cfg_req && !cfg_wr && cfg_addr == sccr_pkg::OFF_TIMER_OVR |=> cfg_rdata[31])
    else $error("VGA decode bit not set.");

endmodule : sccr_regs

/* sccr_eeprom_model.sv */
// Behavioural EEPROM holding the product data table, answering after a set delay.
module sccr_eeprom_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] lat,
  input wire logic ee_req,
  input wire logic ee_write,
  input wire logic [5:0] ee_addr,
  input wire logic [31:0] ee_wdata,
  output logic ee_done,
  output logic [31:0] ee_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [64];
  logic [7:0] wait_cnt;
  initial
  begin
    for (int i = 0; i < 64; i++)
    begin
      mem[i] = {4{i[7:0]}} ^ 32'h5A0000A5;
    end
  end
  // The read bus toggles outside the done cycle, so stale data never looks valid.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_cnt <= 8'h00;
      ee_done <= 1'b0;
      ee_rdata <= 32'hA5A5A5A5;
    end
    else
    begin
      ee_done <= 1'b0;
      ee_rdata <= ~ee_rdata;
      if (ee_req && !ee_done)
      begin
        wait_cnt <= wait_cnt + 8'h01;
        if (wait_cnt == lat)
        begin
          wait_cnt <= 8'h00;
          ee_done <= 1'b1;
          if (ee_write)
            mem[ee_addr] <= ee_wdata;
          else
            ee_rdata <= mem[ee_addr];
        end
      end
    end
  end
endmodule : sccr_eeprom_model

/* tb_sccr_regs.sv */
// Self-checking bench for the capability register slice in both port flavours.
module tb_sccr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, arst_n, ce, cfg_req, cfg_wr, ld_wr, ld_pend, ee_done;
  logic [7:0] cfg_addr, lat;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, ld_data, ee_rdata, ee_wdata, up_rdata, dn_rdata, rd_up, rd_dn;
  logic [31:0] dn_upper, tw0, tw1;
  logic [15:0] dn_data;
  logic [11:0] builtin_replay, replay_limit;
  logic [13:0] builtin_ack, ack_limit;
  logic up_ack, dn_ack, ee_req, ee_write, pm_dis, msi_dis;
  logic [5:0] ee_addr;
  int error_cnt = 0;
  int total_checks = 0;

  sccr_regs #(.UPSTREAM(1'b1)) u_sccr_regs (
    .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(up_ack),
    .cfg_rdata(up_rdata), .ld_wr(ld_wr), .ld_data(ld_data), .ee_req(ee_req),
    .ee_write(ee_write), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_done(ee_done),
    .ee_rdata(ee_rdata), .builtin_replay(builtin_replay), .builtin_ack(builtin_ack),
    .replay_limit(replay_limit), .ack_limit(ack_limit), .pm_cap_disable(pm_dis),
    .msi_cap_disable(msi_dis), .msi_upper_addr(), .msi_data(), .test_word0(tw0),
    .test_word1(tw1));
  sccr_regs #(.UPSTREAM(1'b0)) u_sccr_regs_dn (
    .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(dn_ack),
    .cfg_rdata(dn_rdata), .ld_wr(ld_wr), .ld_data(ld_data), .ee_req(), .ee_write(),
    .ee_addr(), .ee_wdata(), .ee_done(1'b0), .ee_rdata(32'h00000000),
    .builtin_replay(builtin_replay), .builtin_ack(builtin_ack), .replay_limit(),
    .ack_limit(), .pm_cap_disable(), .msi_cap_disable(), .msi_upper_addr(dn_upper),
    .msi_data(dn_data), .test_word0(), .test_word1());
  sccr_eeprom_model u_sccr_eeprom_model (
    .core_clk(core_clk), .arst_n(arst_n), .lat(lat), .ee_req(ee_req),
    .ee_write(ee_write), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_done(ee_done),
    .ee_rdata(ee_rdata));

  // ---------------------------------------------------------------
  // Access and comparison tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask : chk

  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge core_clk);
    #1;
    cfg_req = 1'b1;
    cfg_wr = wr;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = be;
    ld_wr = ld_pend;
    @(posedge core_clk);
    #1;
    cfg_req = 1'b0;
    ld_wr = 1'b0;
    ld_pend = 1'b0;
    rd_up = up_rdata;
    rd_dn = dn_rdata;
    chk("cfg_ack", {30'h0, up_ack, dn_ack}, 32'h3);
  endtask : acc

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] eu, input logic [31:0] ed);
    acc(1'b0, a, 32'h0, 4'h0);
    chk($sformatf("up %h", a), rd_up, eu);
    chk($sformatf("dn %h", a), rd_dn, ed);
  endtask : rd_chk

  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                       input logic [31:0] eu, input logic [31:0] ed);
    acc(1'b1, a, d, be);
    rd_chk(a, eu, ed);
  endtask : wr_rd

  // Completion is seen by polling the operation bit, bounded to catch a hang.
  task automatic pd_poll(input logic done_bit);
    int n;
    n = 0;
    do
    begin
      acc(1'b0, 8'h5C, 32'h0, 4'h0);
      n++;
    end
    while (rd_up[31] !== done_bit && n < 100);
    if (rd_up[31] !== done_bit)
      error_cnt++;
  endtask : pd_poll

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial
  begin
    #200000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    arst_n = 1'b0;
    ce = 1'b1;
    cfg_req = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    ld_wr = 1'b0;
    ld_pend = 1'b0;
    ld_data = 32'h0;
    lat = 8'h03;
    builtin_replay = 12'h5A3;
    builtin_ack = 14'h1C7E;
    repeat (2) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    rd_chk(8'h54, 32'h0, 32'h0);
    rd_chk(8'h58, 32'h0, 32'h0);
    rd_chk(8'h5C, 32'h00006403, 32'h0);
    rd_chk(8'h60, 32'h0, 32'h0);
    rd_chk(8'h64, 32'h0034B009, 32'h0034B009);
    rd_chk(8'h68, 32'h04001060, 32'h04001060);
    rd_chk(8'h6C, 32'h04000800, 32'h04000800);
    rd_chk(8'h70, 32'h80000000, 32'h80000000);
    rd_chk(8'h74, 32'h0, 32'h0);
    chk("limits", {replay_limit, 6'h0, ack_limit}, {12'h5A3, 6'h0, 14'h1C7E});
    wr_rd(8'h54, 32'hFFFFFFFF, 4'hF, 32'h0, 32'hFFFFFFFF);
    wr_rd(8'h58, 32'hFFFFFFFF, 4'hF, 32'h0, 32'h0000FFFF);
    chk("msi", {dn_upper[15:0], dn_data}, 32'hFFFFFFFF);
    wr_rd(8'h64, 32'hFFFFFFFF, 4'hF, 32'h0034B009, 32'h0034B009);
    ce = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("ce_hold", {up_ack, dn_ack, up_rdata[29:0]}, {2'h3, 30'h0034B009});
    ce = 1'b1;
    wr_rd(8'h68, 32'hFFFFFFFF, 4'hF, 32'hFFFFFFFF, 32'hFFFFFFFF);
    wr_rd(8'h68, 32'h0, 4'h1, 32'hFFFFFF00, 32'hFFFFFF00);
    wr_rd(8'h6C, 32'h0, 4'hF, 32'h0, 32'h0);
    chk("test_word0", tw0, 32'hFFFFFF00);
    chk("test_word1", tw1, 32'h00000000);
    wr_rd(8'h70, 32'hFFFFFFFF, 4'hF, 32'hFFFF1FFF, 32'hFFFF1FFF);
    chk("limits", {replay_limit, 6'h0, ack_limit}, {12'hFFF, 6'h0, 14'h3FFF});
    wr_rd(8'h70, 32'h0ABC0123, 4'hF, 32'h8ABC0123, 32'h8ABC0123);
    chk("limits", {replay_limit, 6'h0, ack_limit}, {12'h5A3, 6'h0, 14'h1C7E});
    ld_pend = 1'b1;
    ld_data = 32'hFFFFFFFF;
    wr_rd(8'h70, 32'h0, 4'hF, 32'hFFFF7FFF, 32'hFFFF7FFF);
    chk("disables", {30'h0, pm_dis, msi_dis}, 32'h3);
    wr_rd(8'h60, 32'hCAFE0123, 4'hF, 32'hCAFE0123, 32'h0);
    lat = 8'h08;
    acc(1'b1, 8'h5C, 32'h80A80000, 4'hF);
    chk("ee_cmd", {ee_req, ee_write, ee_addr, 24'h0}, {1'b1, 1'b1, 6'h2A, 24'h0});
    chk("ee_wdata", ee_wdata, 32'hCAFE0123);
    acc(1'b1, 8'h60, 32'h11111111, 4'hF);
    rd_chk(8'h5C, 32'h80A86403, 32'h0);
    pd_poll(1'b0);
    chk("pd_wr_done", rd_up, 32'h00A86403);
    rd_chk(8'h60, 32'hCAFE0123, 32'h0);
    wr_rd(8'h60, 32'h0, 4'hF, 32'h0, 32'h0);
    lat = 8'h00;
    acc(1'b1, 8'h5C, 32'h00A80000, 4'hF);
    pd_poll(1'b1);
    chk("pd_rd_done", rd_up, 32'h80A86403);
    rd_chk(8'h60, 32'hCAFE0123, 32'h0);
    lat = 8'h28;
    acc(1'b1, 8'h5C, 32'h00FC0000, 4'hF);
    chk("ee_rd_cmd", {ee_req, ee_write, ee_addr, 24'h0}, {1'b1, 1'b0, 6'h3F, 24'h0});
    pd_poll(1'b1);
    chk("pd_rd_done", rd_up, 32'h80FC6403);
    rd_chk(8'h60, 32'h653F3F9A, 32'h0);
    finish_test();
  end
endmodule : tb_sccr_regs
